// ===== bcd_digit.sv
/*
  One decimal digit counter with clear and step, used twice in cascade.
  Assumes clear and step are one-cycle levels on the system clock.
*/
`timescale 1ns/1ps
module bcd_digit
(
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       clear_i,
   input  wire logic       step_i,
   output logic [3:0]      value_o,
   output logic            wrap_o
);

   // -----------------------------------------------------------------
   // nine-to-zero detect; a clear in the same cycle cancels the carry
   // -----------------------------------------------------------------
   assign wrap_o = step_i & ~clear_i & (value_o == chrono_pkg::BCD_MAX);

   // digit register
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || clear_i)
         value_o <= chrono_pkg::DIGIT_RESET;
      else if (wrap_o)
         value_o <= chrono_pkg::DIGIT_RESET;
      else if (step_i)
         value_o <= value_o + 4'h1;
   end

   // RULE13 decimal range
   a_digit_range : assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RULE13
      value_o <= chrono_pkg::BCD_MAX)
      else $error("digit left the decimal range");

endmodule // bcd_digit

// ===== chrono_pkg.sv
/*
  Shared constants, register map and carrier types for the tick timer and
  the two-digit chrono (stopwatch) block.
  Assumes a single 100 MHz clock and a word-wide Avalon-MM register port.
*/
package chrono_pkg;

   // -----------------------------------------------------------------
   // clocking
   // -----------------------------------------------------------------
   localparam int CLK_HZ   = 100_000_000;
   localparam int BASE_HZ  = 256;                 // prescaler output rate
   localparam int BASE_DIV = CLK_HZ / BASE_HZ;    // cycles per base period

   // -----------------------------------------------------------------
   // tick counter layout
   // -----------------------------------------------------------------
   localparam int TICK_BITS = 7;                  // 128 Hz .. 2 Hz stages
   localparam int TAP_LSB   = 3;                  // 16 Hz stage
   localparam int TAP32_BIT = 2;
   localparam int TAP8_BIT  = 4;
   localparam int TAP2_BIT  = 6;

   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [9:0] IDX_TICK_VALUE  = 10'h2e0;
   localparam logic [9:0] IDX_HUNDREDTHS  = 10'h2e1;
   localparam logic [9:0] IDX_TENTHS      = 10'h2e2;
   localparam logic [9:0] IDX_CHRONO_EN   = 10'h2e6;
   localparam logic [9:0] IDX_TICK_EN     = 10'h2e8;
   localparam logic [9:0] IDX_TICK_FLAG   = 10'h2e9;
   localparam logic [9:0] IDX_CHRONO_FLAG = 10'h2ea;
   localparam logic [9:0] IDX_CONTROL     = 10'h2ee;

   // control register bit positions
   localparam int CTL_TICK_CLEAR   = 3;
   localparam int CTL_RUN          = 2;
   localparam int CTL_CHRONO_CLEAR = 1;

   // -----------------------------------------------------------------
   // reset values and counting constants
   // -----------------------------------------------------------------
   localparam logic [TICK_BITS-1:0] TICK_RESET = 7'h00;
   localparam logic [3:0]  DIGIT_RESET  = 4'h0;
   localparam logic [3:0]  BCD_MAX      = 4'h9;
   localparam logic [2:0]  TICK_EN_RESET = 3'h0;
   localparam logic [1:0]  CHRONO_EN_RESET = 2'h0;
   localparam logic        RUN_RESET    = 1'h0;
   localparam logic [1:0]  STEP_SHORT   = 2'h2;   // base periods per step
   localparam logic [1:0]  STEP_LONG    = 2'h3;
   localparam logic [27:0] READ_PAD     = 28'h000_0000;

   // -----------------------------------------------------------------
   // carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic tick2;
      logic tick8;
      logic tick32;
   } tick_trio_t;

   typedef struct packed {
      logic second_wrap;
      logic tenth_wrap;
   } chrono_pair_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;

   // step length of the low digit: odd digits take three base periods;
   // digit 0 also takes three in a long decade (26 periods instead of 25);
   // high digits 1,3,5,6,8,9 give long decades: 4 x 25 + 6 x 26 = 256
   function automatic logic [1:0] step_periods(input logic [3:0] lo,
                                               input logic [3:0] hi);
      logic long_decade;
      long_decade = !(hi == 4'h0 || hi == 4'h2 || hi == 4'h4 || hi == 4'h7);
      if (lo[0] || (long_decade && lo == DIGIT_RESET))
         step_periods = STEP_LONG;
      else
         step_periods = STEP_SHORT;
   endfunction

endpackage

// ===== chrono_timers.sv
/*
  Tick timer (7-stage binary counter on the 256 Hz base) and two-digit
  chrono counter, with flags, enables and request lines, behind an
  Avalon-MM slave with waitrequest.
  Assumes all inputs synchronous to ref_clk_i; the CPU keeps its own
  interrupt-enable state and reads flags only with interrupts off.
// How it works
// RULE1: upper four tick stages read as one nibble; writes ignored.
// RULE2: reset clears the tick value nibble.
// RULE3: three read/write enables for 32, 8 and 2 Hz ticks.
// RULE4: software writes tick enables only with interrupts off.
// RULE5: reset clears all three tick enables.
// RULE6: falling edge of 32/8/2 Hz sets its flag regardless of enable.
// RULE7: reading tick flags clears them; writes ignored; top bit reads zero.
// RULE8: software reads tick flags only with interrupts off.
// RULE9: reset clears all tick flags.
// RULE10: writing one to tick clear zeroes the counter; it resumes; reads zero.
// RULE11: software should read flags after a tick clear to drop stray ones.
// RULE12: the 2 Hz stage feeds the watchdog; a clear may step it.
// RULE13: chrono is two cascaded decimal digits fed from the 256 Hz base.
// RULE14: low digit steps per hundredth; its wrap steps the high digit.
// RULE15: low digit steps every two or three base periods; decade 25 or 26.
// RULE16: per second four 25-period and six 26-period decades.
// RULE17: each digit wrap nine-to-zero sets its flag regardless of enable.
// RULE18: separate enables for tenth and second wraps gate only requests.
// RULE19: run bit starts and stops; stopped count holds and resumes.
// RULE20: chrono clear zeroes both digits; running restarts; reads zero.
// RULE21: reading chrono flags clears them; software reads with interrupts off.
// RULE22: software stops, reads both digits, restarts within 976 us.
// RULE23: each request line is flag AND enable.
// RULE24: step placement within a decade is fixed by this design.
*/
`timescale 1ns/1ps
module chrono_timers
#(
   parameter int BASE_DIV = chrono_pkg::BASE_DIV
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [11:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             tick32_irq_o,
   output logic             tick8_irq_o,
   output logic             tick2_irq_o,
   output logic             tenth_irq_o,
   output logic             second_irq_o,
   output logic             watchdog_step_o
);

   localparam int DIV_W = $clog2(BASE_DIV);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   chrono_pkg::bus_state_t          bus_state;
   chrono_pkg::bus_state_t          next_bus_state;
   logic [DIV_W-1:0]                base_cnt;
   logic [chrono_pkg::TICK_BITS-1:0] tick_cnt;
   logic [chrono_pkg::TICK_BITS-1:0] next_tick_cnt;
   chrono_pkg::tick_trio_t          tick_enable;
   chrono_pkg::tick_trio_t          tick_flag;
   chrono_pkg::chrono_pair_t        chrono_enable;
   chrono_pkg::chrono_pair_t        chrono_flag;
   logic                            chrono_run;
   logic [1:0]                      phase;
   logic [3:0]                      hundredths_counter;
   logic [3:0]                      tenths_counter;

   wire  [9:0]  reg_index;
   wire         accept;
   wire         wr_accept;
   wire         rd_accept;
   wire         base_tick;
   wire         tick_counter_clear;
   wire         chrono_clear;
   wire [chrono_pkg::TICK_BITS-1:0] tick_fall;
   wire         fall32;
   wire         fall8;
   wire         fall2;
   wire [3:0]   tick_value;
   wire [3:0]   read_mux;
   wire [2:0]   tick_read_clear;
   wire [1:0]   chrono_read_clear;
   wire [1:0]   step_len;
   wire         lo_step;
   wire         lo_wrap;
   wire         hi_wrap;
   wire         base_run;
   wire [1:0]   next_phase;

   // -----------------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------------

   // request is taken on the edge after the second request cycle
   assign reg_index = avs_address_i[11:2];
   assign accept    = (bus_state == chrono_pkg::BUS_ACK);
   assign wr_accept = accept & avs_write_i & avs_byteenable_i[0];
   assign rd_accept = accept & avs_read_i;
   assign next_bus_state = (bus_state == chrono_pkg::BUS_IDLE && (avs_read_i || avs_write_i))
                           ? chrono_pkg::BUS_ACK : chrono_pkg::BUS_IDLE;

   // one wait cycle per access, then a single accept cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         bus_state <= chrono_pkg::BUS_IDLE;
      else
         bus_state <= next_bus_state;
   end
   assign avs_waitrequest_o = bus_state[0];

   // RULE1 taps in a nibble
   assign tick_value = tick_cnt[chrono_pkg::TAP_LSB +: 4];

   // read decode; unmapped indices and unused bits read as zero
   assign read_mux =
      (reg_index == chrono_pkg::IDX_TICK_VALUE)  ? tick_value :
      (reg_index == chrono_pkg::IDX_HUNDREDTHS)  ? hundredths_counter :
      (reg_index == chrono_pkg::IDX_TENTHS)      ? tenths_counter :
      (reg_index == chrono_pkg::IDX_CHRONO_EN)   ? {2'h0, chrono_enable} :
      (reg_index == chrono_pkg::IDX_TICK_EN)     ? {1'h0, tick_enable} :
      (reg_index == chrono_pkg::IDX_TICK_FLAG)   ? {1'h0, tick_flag} :
      (reg_index == chrono_pkg::IDX_CHRONO_FLAG) ? {2'h0, chrono_flag} :
      (reg_index == chrono_pkg::IDX_CONTROL)     ? {1'h0, chrono_run, 2'h0} :
      4'h0;

   // snapshot taken when the read is first seen; stands through the accept
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         avs_readdata_o <= {chrono_pkg::READ_PAD, 4'h0};
      else if (bus_state == chrono_pkg::BUS_IDLE && avs_read_i)
         avs_readdata_o <= {chrono_pkg::READ_PAD, read_mux};
   end

   // RULE7 clear only what was shown, so a later event survives the read
   assign tick_read_clear = (rd_accept && reg_index == chrono_pkg::IDX_TICK_FLAG)
                            ? avs_readdata_o[2:0] : 3'h0;
   // RULE21 same for chrono flags
   assign chrono_read_clear = (rd_accept && reg_index == chrono_pkg::IDX_CHRONO_FLAG)
                              ? avs_readdata_o[1:0] : 2'h0;

   // RULE10 write-one strobes, nothing stored
   assign tick_counter_clear = wr_accept && reg_index == chrono_pkg::IDX_CONTROL
                               && avs_writedata_i[chrono_pkg::CTL_TICK_CLEAR];
   // RULE20 write-one strobe
   assign chrono_clear = wr_accept && reg_index == chrono_pkg::IDX_CONTROL
                         && avs_writedata_i[chrono_pkg::CTL_CHRONO_CLEAR];

   // RULE3 enables, run bit; RULE5 reset values
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         tick_enable   <= chrono_pkg::TICK_EN_RESET;
         chrono_enable <= chrono_pkg::CHRONO_EN_RESET;
         chrono_run    <= chrono_pkg::RUN_RESET;
      end
      else if (wr_accept)
      begin
         if (reg_index == chrono_pkg::IDX_TICK_EN)
            tick_enable <= avs_writedata_i[2:0];
         if (reg_index == chrono_pkg::IDX_CHRONO_EN)
            chrono_enable <= avs_writedata_i[1:0];
         // RULE19 run and stop
         if (reg_index == chrono_pkg::IDX_CONTROL)
            chrono_run <= avs_writedata_i[chrono_pkg::CTL_RUN];
      end
   end

   // -----------------------------------------------------------------
   // base rate divider
   // -----------------------------------------------------------------

   // free running; a tick clear does not touch it, as the prescaler is apart
   assign base_tick = (base_cnt == DIV_W'(BASE_DIV - 1));

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || base_tick)
         base_cnt <= '0;
      else
         base_cnt <= base_cnt + DIV_W'(1);
   end

   // -----------------------------------------------------------------
   // tick timer
   // -----------------------------------------------------------------

   // RULE10 clear wins over the count; counting resumes next base tick
   assign next_tick_cnt = tick_counter_clear ? chrono_pkg::TICK_RESET
                        : base_tick ? tick_cnt + 7'h01 : tick_cnt;
   // RULE6 falling edges, a clear of a high stage counts as one too
   assign tick_fall = tick_cnt & ~next_tick_cnt;
   assign fall32    = tick_fall[chrono_pkg::TAP32_BIT];
   assign fall8     = tick_fall[chrono_pkg::TAP8_BIT];
   assign fall2     = tick_fall[chrono_pkg::TAP2_BIT];

   // RULE2 counter; RULE9 flags; RULE12 watchdog feed
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         tick_cnt        <= chrono_pkg::TICK_RESET;
         tick_flag       <= chrono_pkg::TICK_EN_RESET;
         watchdog_step_o <= 1'h0;
      end
      else
      begin
         tick_cnt        <= next_tick_cnt;
         // RULE6 set wins over the read clear
         tick_flag       <= (tick_flag & ~tick_read_clear) | {fall2, fall8, fall32};
         watchdog_step_o <= fall2;
      end
   end

   // -----------------------------------------------------------------
   // chrono digits
   // -----------------------------------------------------------------

   // RULE15 RULE16 RULE24 step length from the fixed pattern
   assign step_len   = chrono_pkg::step_periods(hundredths_counter, tenths_counter);
   assign base_run   = chrono_run & base_tick;
   assign lo_step    = base_run & ~chrono_clear & (phase + 2'h1 == step_len);
   assign next_phase = chrono_clear ? 2'h0 : lo_step ? 2'h0
                     : base_run ? phase + 2'h1 : phase;

   // RULE19 phase holds while stopped, so a short stop loses no time
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         phase <= 2'h0;
      else
         phase <= next_phase;
   end

   // RULE13 RULE14 low digit wrap feeds the high digit
   bcd_digit u_hundredths
   (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (chrono_clear),
      .step_i    (lo_step),
      .value_o   (hundredths_counter),
      .wrap_o    (lo_wrap)
   );

   bcd_digit u_tenths
   (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (chrono_clear),
      .step_i    (lo_wrap),
      .value_o   (tenths_counter),
      .wrap_o    (hi_wrap)
   );

   // -----------------------------------------------------------------
   // flags and request lines
   // -----------------------------------------------------------------

   // RULE17 wraps set flags regardless of enable; RULE23 requests gated
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         chrono_flag  <= chrono_pkg::CHRONO_EN_RESET;
         tick32_irq_o <= 1'h0;
         tick8_irq_o  <= 1'h0;
         tick2_irq_o  <= 1'h0;
         tenth_irq_o  <= 1'h0;
         second_irq_o <= 1'h0;
      end
      else
      begin
         chrono_flag  <= (chrono_flag & ~chrono_read_clear) | {hi_wrap, lo_wrap};
         tick32_irq_o <= tick_flag.tick32 & tick_enable.tick32;
         tick8_irq_o  <= tick_flag.tick8 & tick_enable.tick8;
         tick2_irq_o  <= tick_flag.tick2 & tick_enable.tick2;
         // RULE18 enables gate the request only
         tenth_irq_o  <= chrono_flag.tenth_wrap & chrono_enable.tenth_wrap;
         second_irq_o <= chrono_flag.second_wrap & chrono_enable.second_wrap;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------

   a_reset_state_zero : assert property ( // RULE2
      $fell(sys_rst_i) |-> tick_value == 4'h0 && tick_enable == 3'h0
                           && tick_flag == 3'h0)
      else $error("state not zero after reset");

   a_tick32_falling : assert property ( // RULE6
      fall32 |=> tick_flag.tick32 ##1 (tick_flag.tick32 || $past(rd_accept)))
      else $error("32 Hz flag not set on falling edge");

   a_flag_read_clear : assert property ( // RULE7
      rd_accept && reg_index == chrono_pkg::IDX_TICK_FLAG && avs_readdata_o[1]
      && !fall8 |=> !tick_flag.tick8)
      else $error("8 Hz flag survived its read");

   a_tick_clear_zero : assert property ( // RULE10
      tick_counter_clear |=> tick_cnt == chrono_pkg::TICK_RESET)
      else $error("tick counter not cleared");

   a_watchdog_feed : assert property ( // RULE12
      $fell(tick_cnt[chrono_pkg::TAP2_BIT]) |-> watchdog_step_o)
      else $error("watchdog step missing");

   a_step_spacing : assert property ( // RULE15
      lo_step |-> phase == 2'h1 || phase == 2'h2)
      else $error("low digit step spacing wrong");

   a_cascade_only : assert property ( // RULE14
      $changed(tenths_counter) && !$past(chrono_clear) |-> $past(lo_wrap))
      else $error("high digit moved without carry");

   a_stop_holds : assert property ( // RULE19
      !chrono_run && !chrono_clear |=> $stable(hundredths_counter) && $stable(phase))
      else $error("stopped chrono moved");

   a_chrono_clear : assert property ( // RULE20
      chrono_clear |=> hundredths_counter == 4'h0 && tenths_counter == 4'h0)
      else $error("chrono clear missed");

   a_wrap_flag : assert property ( // RULE17
      hi_wrap |=> chrono_flag.second_wrap)
      else $error("second flag not set on wrap");

   a_request_gate : assert property ( // RULE23
      second_irq_o |-> $past(chrono_flag.second_wrap) && $past(chrono_enable.second_wrap))
      else $error("second request without flag and enable");

endmodule // chrono_timers

// ===== chrono_timers_tb.sv
/*
  Self-checking bench for the tick timer and two-digit chrono block.
  Assumes the block answers every bus access after one wait cycle and
  is built with a short base divider so that one second is 2048 cycles.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end

module chrono_timers_tb;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   localparam int BDIV = 8;
   logic        ref_clk_i;
   logic        sys_rst_i;
   logic [11:0] avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        tick32_irq_o;
   logic        tick8_irq_o;
   logic        tick2_irq_o;
   logic        tenth_irq_o;
   logic        second_irq_o;
   logic        watchdog_step_o;
   logic [4:0]  irq_vec;
   int          error_cnt;
   int          checks;
   int          cyc = 0;

   assign irq_vec = {second_irq_o, tenth_irq_o, tick2_irq_o, tick8_irq_o, tick32_irq_o};

   chrono_timers #(.BASE_DIV(BDIV)) DUT
   (
      .ref_clk_i         (ref_clk_i),
      .sys_rst_i         (sys_rst_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .tick32_irq_o      (tick32_irq_o),
      .tick8_irq_o       (tick8_irq_o),
      .tick2_irq_o       (tick2_irq_o),
      .tenth_irq_o       (tenth_irq_o),
      .second_irq_o      (second_irq_o),
      .watchdog_step_o   (watchdog_step_o)
   );

   // clock and free cycle count for interval checks
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) cyc <= cyc + 1;

   // -----------------------------------------------------------------
   // bus tasks
   // -----------------------------------------------------------------
   // request held until waitrequest is seen low, then released; no local
   // bound here, a hung slave is caught by the watchdog
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [3:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
      int n;
      avs_address_i    <= {idx, 2'b00};
      avs_read_i       <= !wr;
      avs_write_i      <= wr;
      avs_writedata_i  <= {28'h000_0000, d};
      avs_byteenable_i <= be;
      n = 0;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0);
      // one wait cycle, then the accept cycle
      `CHK(n, 2)
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [3:0] d, input logic [3:0] be = 4'hf);
      logic [31:0] rd;
      xfer(1'b1, idx, d, be, rd);
   endtask

   task automatic rd_val(input logic [9:0] idx, output logic [31:0] v);
      xfer(1'b0, idx, 4'h0, 4'hf, v);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [3:0] exp);
      logic [31:0] rd;
      xfer(1'b0, idx, 4'h0, 4'hf, rd);
      `CHK(rd, {28'h000_0000, exp})
   endtask

   // bounded wait for one request line; returns the cycle it was seen
   task automatic wait_irq(input int idx, input int lim, output int t);
      int i;
      t = -1;
      for (i = 0; i < lim; i++)
      begin
         @(posedge ref_clk_i);
         if (irq_vec[idx] === 1'b1)
         begin
            t = cyc;
            break;
         end
      end
      `CHK(t >= 0, 1'b1)
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_tick;
      int t;
      int i;
      rd_chk(chrono_pkg::IDX_TICK_VALUE, 4'h0);
      rd_chk(chrono_pkg::IDX_TICK_EN, 4'h0);
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h0);
      rd_chk(10'h2e3, 4'h0);
      wr(chrono_pkg::IDX_TICK_VALUE, 4'hf);
      rd_chk(chrono_pkg::IDX_TICK_VALUE, 4'h0);
      wr(chrono_pkg::IDX_TICK_EN, 4'hf);
      rd_chk(chrono_pkg::IDX_TICK_EN, 4'h7);
      wr(chrono_pkg::IDX_TICK_EN, 4'h0, 4'h0);
      rd_chk(chrono_pkg::IDX_TICK_EN, 4'h7);
      wr(chrono_pkg::IDX_TICK_FLAG, 4'hf);
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h0);
      wr(chrono_pkg::IDX_CONTROL, 4'h8);
      rd_chk(chrono_pkg::IDX_CONTROL, 4'h0);
      // flags read with interrupts off; the clear dropped the 32 Hz stage
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h1);
      wait_irq(0, 100, t);
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h1);
      @(posedge ref_clk_i);
      `CHK(tick32_irq_o, 1'b0)
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h0);
      wr(chrono_pkg::IDX_TICK_EN, 4'h0);
      repeat (70) @(posedge ref_clk_i);
      `CHK(tick32_irq_o, 1'b0)
      // counter stands at 18 here: only the 8 Hz tap is high
      rd_chk(chrono_pkg::IDX_TICK_VALUE, 4'h2);
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h1);
      wr(chrono_pkg::IDX_TICK_EN, 4'h7);
      for (i = 0; i < 1000; i++)
      begin
         @(posedge ref_clk_i);
         if (watchdog_step_o === 1'b1)
            break;
      end
      `CHK(watchdog_step_o, 1'b1)
      repeat (2) @(posedge ref_clk_i);
      `CHK(tick2_irq_o, 1'b1)
      `CHK(tick8_irq_o, 1'b1)
      rd_chk(chrono_pkg::IDX_TICK_FLAG, 4'h7);
      rd_chk(chrono_pkg::IDX_TICK_VALUE, 4'h0);
   endtask

   task automatic t_chrono;
      int t0;
      int t1;
      logic [31:0] h;
      rd_chk(chrono_pkg::IDX_HUNDREDTHS, 4'h0);
      rd_chk(chrono_pkg::IDX_CHRONO_FLAG, 4'h0);
      wr(chrono_pkg::IDX_CHRONO_EN, 4'h3);
      rd_chk(chrono_pkg::IDX_CHRONO_EN, 4'h3);
      wr(chrono_pkg::IDX_CONTROL, 4'h6);
      rd_chk(chrono_pkg::IDX_CONTROL, 4'h4);
      wait_irq(3, 260, t0);
      rd_chk(chrono_pkg::IDX_TENTHS, 4'h1);
      rd_chk(chrono_pkg::IDX_HUNDREDTHS, 4'h0);
      rd_chk(chrono_pkg::IDX_CHRONO_FLAG, 4'h1);
      rd_chk(chrono_pkg::IDX_CHRONO_FLAG, 4'h0);
      // stopped count must hold across several base periods
      // stop, then read both digits
      wr(chrono_pkg::IDX_CONTROL, 4'h0);
      rd_val(chrono_pkg::IDX_HUNDREDTHS, h);
      rd_chk(chrono_pkg::IDX_TENTHS, 4'h1);
      repeat (100) @(posedge ref_clk_i);
      rd_chk(chrono_pkg::IDX_HUNDREDTHS, h[3:0]);
      wr(chrono_pkg::IDX_CONTROL, 4'h2);
      repeat (100) @(posedge ref_clk_i);
      rd_chk(chrono_pkg::IDX_HUNDREDTHS, 4'h0);
      rd_chk(chrono_pkg::IDX_TENTHS, 4'h0);
      // only the second request enabled; tenth flag still sets
      wr(chrono_pkg::IDX_CHRONO_EN, 4'h2);
      wr(chrono_pkg::IDX_CONTROL, 4'h4);
      wait_irq(4, 2200, t0);
      `CHK(tenth_irq_o, 1'b0)
      rd_chk(chrono_pkg::IDX_CHRONO_FLAG, 4'h3);
      wait_irq(4, 2200, t1);
      `CHK(t1 - t0, 256 * BDIV)
   endtask

   // -----------------------------------------------------------------
   // run control
   // -----------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // generous bound: the scenarios need about 6000 cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      error_cnt++;
      report_and_stop();
   end

   initial
   begin
      error_cnt        = 0;
      checks           = 0;
      sys_rst_i        = 1'b1;
      avs_address_i    = 12'h000;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = 32'h0000_0000;
      avs_byteenable_i = 4'h0;
      repeat (12) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_tick();
      t_chrono();
      report_and_stop();
   end
endmodule // chrono_timers_tb
